// *** accel_spi_defs.svh ***
// offsets, field positions, codes and reset values of the sensor spi command slave
`ifndef ACCEL_SPI_DEFS_SVH
`define ACCEL_SPI_DEFS_SVH

// ==========================================================
// frame geometry
`define FRAME_MSB 15
`define FRAME_EDGES 5'h10
`define EDGE_CNT_MAX 5'h1f
`define ADDR_CAPTURE_EDGES 5'h08

// ==========================================================
// command fields
`define CMD_BIT_HI 15
`define CMD_AXIS_BIT 14
`define CMD_ACC_BIT 13
`define CMD_ADDR_HI 12
`define CMD_ADDR_LO 8
`define OP_UNUSED 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_TEST 2'h3

// ==========================================================
// response fields and status codes
`define RSP_AXIS_BIT 13
`define RSP_PARITY_BIT 12
`define ST_NONE 2'h0
`define ST_ACCEL 2'h1
`define ST_SELF 2'h2
`define ST_ERROR 2'h3

// ==========================================================
// error flag positions inside the ten low bits
`define FL_REQ_BIT 1
`define FL_SPI_BIT 2
`define FL_HE_BIT 3
`define FL_ND_BIT 4
`define FL_CNC_BIT 5

// request-error frame, odd parity already applied
`define REQ_ERR_FRAME 16'h0c02

// ==========================================================
// register addresses and bit positions
`define CTRL_ADDR 5'h0a
`define STAT_ADDR 5'h10
`define CTRL_ST0_BIT 0
`define CTRL_ST1_BIT 1
`define CTRL_HIGHPASS_BYPASS_BIT_BIT 3
`define CTRL_CE_BIT 4
`define STAT_IDE_BIT 7
`define STAT_OSCF_BIT 6
`define STAT_INIT_BIT 5
`define STAT_TF_BIT 4
`define STAT_HPF_BIT 3
`define STAT_OFFY_BIT 2
`define STAT_OFFX_BIT 1
`define STAT_RES_BIT 0

`endif

// *** accel_spi_pkg.sv ***
// shared types of the sensor spi command slave
package accel_spi_pkg;

    typedef enum logic [1:0] {FR_IDLE, FR_ACTIVE, FR_IGNORED} frame_state_t;

    typedef struct packed {
        logic parity_err;
        logic osc_fault;
        logic osc_running;
        logic over_temp;
        logic offset_y;
        logic offset_x;
    } sensor_faults_t;

    typedef struct packed {
        logic highpass_bypass_bit;
        logic selftest_direction_bit;
        logic selftest_enable_bit;
    } ctrl_bits_t;

endpackage : accel_spi_pkg

// *** accel_sensor_spi_command_slave.sv ***
// spi command slave of a dual-axis sensor: framing, decode and queued response
//
// Notes on behaviour
// - spi mode 0, msb first, clock idles low, device always slave
// - command of one frame is answered during the next frame
// - serial input and clock ignored while chip select is inactive
// - first frame after reset sends the request-error response
// - acceleration request: bit 15 zero, bit 13 one, bit 14 picks axis
// - acceleration response: axis bit 13, status bits 11:10, sample bits 9:0
// - axis 0 is x, axis 1 is y
// - status 01 data, 10 self-test, 11 error; never 00 for acceleration
// - error status puts error flags in the ten low bits
// - no-data flag during initialisation and on first request after it
// - hardware error for heat, offset, parity, and oscillator fault while running
// - acceleration request with bit 15 set gives conditions-wrong frame plus flags
// - with bit 13 clear, bits 15:14 select unused, write, read, test
// - other commands always complete; report only oscillator, spi or request errors
// - write carries address 12:8 and data 7:0; only control register writable
// - write response shows readable control bits in the low byte
// - read ignores command low byte, returns register in bits 7:0
// - device test returns status register in bits 7:0
// - status bit 0 set by reset, cleared by control clear-error bit except during the second init phase
// - operation code 00 gives request-error response
// - spi error unless exactly 16 rising edges and clock low at both select edges
// - first init phase ignores spi; second phase serves registers, no acceleration
// - oscillator fault holds serial output high throughout chip select
`include "accel_spi_defs.svh"

module accel_sensor_spi_command_slave (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_din,
    output logic spi_dout,
    output logic spi_dout_oe,
    input wire logic init_phase_one,
    input wire logic init_phase_two,
    input wire accel_spi_pkg::sensor_faults_t faults,
    input wire logic [9:0] sample_x,
    input wire logic [9:0] sample_y,
    input wire logic [7:0] aux_rd_data,
    output logic [4:0] aux_rd_addr,
    output accel_spi_pkg::ctrl_bits_t ctrl,
    output logic clear_error_pulse
);
    import accel_spi_pkg::*;

    // ==========================================================
    // helpers

    function automatic logic [15:0] with_parity(input logic [15:0] f);
        logic [15:0] r;
        r = f;
        r[`RSP_PARITY_BIT] = 1'b0;
        r[`RSP_PARITY_BIT] = ~(^r);
        return r;
    endfunction : with_parity

    function automatic logic [15:0] error_frame(input logic [9:0] flags);
        return with_parity({4'h0, `ST_ERROR, flags});
    endfunction : error_frame

    function automatic logic [7:0] ctrl_byte(input ctrl_bits_t c);
        logic [7:0] b;
        b = 8'h00;
        b[`CTRL_HIGHPASS_BYPASS_BIT_BIT] = c.highpass_bypass_bit;
        b[`CTRL_ST1_BIT] = c.selftest_direction_bit;
        b[`CTRL_ST0_BIT] = c.selftest_enable_bit;
        return b;
    endfunction : ctrl_byte

    // ==========================================================
    // pin synchronisers
    logic cs_n_s1_q, cs_n_s2_q, cs_n_s3_q;
    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic din_s1_q, din_s2_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cs_n_s1_q <= 1'b1;
            cs_n_s2_q <= 1'b1;
            cs_n_s3_q <= 1'b1;
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
        end else begin
            cs_n_s1_q <= spi_cs_n;
            cs_n_s2_q <= cs_n_s1_q;
            cs_n_s3_q <= cs_n_s2_q;
            sclk_s1_q <= spi_sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            din_s1_q <= spi_din;
            din_s2_q <= din_s1_q;
        end
    end

    logic cs_fall, cs_rise, sclk_rise, sclk_fall;
    assign cs_fall = cs_n_s3_q & ~cs_n_s2_q;
    assign cs_rise = ~cs_n_s3_q & cs_n_s2_q;
    assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
    assign sclk_fall = ~sclk_s2_q & sclk_s3_q;

    // ==========================================================
    // frame state
    frame_state_t state_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= FR_IDLE;
        end else begin
            unique case (state_q)
                FR_IDLE: begin
                    if (cs_fall) begin
                        state_q <= init_phase_one ? FR_IGNORED : FR_ACTIVE;
                    end
                end
                FR_ACTIVE, FR_IGNORED: begin
                    if (cs_rise) begin
                        state_q <= FR_IDLE;
                    end
                end
            endcase
        end
    end

    logic active, frame_end, load;
    assign active = (state_q == FR_ACTIVE);
    assign frame_end = active & cs_rise;
    assign load = (state_q == FR_IDLE) & cs_fall & ~init_phase_one;

    // ==========================================================
    // receive side
    logic [15:0] rx_q;
    logic [4:0] cnt_q;
    logic sclk_hi_q;
    logic [4:0] aux_addr_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_q <= 16'h0000;
            cnt_q <= 5'h00;
            sclk_hi_q <= 1'b0;
        end else if (load) begin
            rx_q <= 16'h0000;
            cnt_q <= 5'h00;
            sclk_hi_q <= sclk_s2_q;
        end else if (active && sclk_rise) begin
            rx_q <= {rx_q[14:0], din_s2_q};
            if (cnt_q != `EDGE_CNT_MAX) begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // address is offered early so the outside read data settles before the frame ends
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aux_addr_q <= 5'h00;
        end else if (active && cnt_q == `ADDR_CAPTURE_EDGES) begin
            aux_addr_q <= rx_q[4:0];
        end
    end

    // ==========================================================
    // decode and response
    logic spi_err, is_accel, hw_fault, no_data, ctrl_hit;
    logic [1:0] op;
    logic [4:0] addr;
    logic [9:0] sample_sel;
    logic [7:0] stat_byte, rd_byte;
    logic [9:0] flags;
    logic [15:0] resp_d;
    ctrl_bits_t ctrl_q, ctrl_new;
    logic devres_q, nd_pending_q, ce_pulse_q;

    // edge count and clock level at select edges
    assign spi_err = sclk_hi_q | sclk_s2_q | (cnt_q != `FRAME_EDGES);
    assign is_accel = rx_q[`CMD_ACC_BIT];
    assign op = rx_q[`CMD_BIT_HI:`CMD_AXIS_BIT];
    assign addr = rx_q[`CMD_ADDR_HI:`CMD_ADDR_LO];
    assign ctrl_hit = (addr == `CTRL_ADDR);
    assign sample_sel = rx_q[`CMD_AXIS_BIT] ? sample_y : sample_x;
    assign hw_fault = faults.over_temp | faults.offset_x | faults.offset_y
                    | faults.parity_err | (faults.osc_fault & faults.osc_running);
    // no data while initialising or first after
    assign no_data = init_phase_two | nd_pending_q;
    assign ctrl_new.highpass_bypass_bit = rx_q[`CTRL_HIGHPASS_BYPASS_BIT_BIT];
    assign ctrl_new.selftest_direction_bit = rx_q[`CTRL_ST1_BIT];
    assign ctrl_new.selftest_enable_bit = rx_q[`CTRL_ST0_BIT];

    always_comb begin
        stat_byte = 8'h00;
        stat_byte[`STAT_IDE_BIT] = faults.parity_err;
        stat_byte[`STAT_OSCF_BIT] = faults.osc_fault;
        stat_byte[`STAT_INIT_BIT] = init_phase_one | init_phase_two;
        stat_byte[`STAT_TF_BIT] = faults.over_temp;
        stat_byte[`STAT_HPF_BIT] = ~ctrl_q.highpass_bypass_bit;
        stat_byte[`STAT_OFFY_BIT] = faults.offset_y;
        stat_byte[`STAT_OFFX_BIT] = faults.offset_x;
        stat_byte[`STAT_RES_BIT] = devres_q;
    end

    always_comb begin
        if (ctrl_hit) begin
            rd_byte = ctrl_byte(ctrl_q);
        end else if (addr == `STAT_ADDR) begin
            rd_byte = stat_byte;
        end else begin
            rd_byte = aux_rd_data;
        end
    end

    always_comb begin
        flags = 10'h000;
        flags[`FL_ND_BIT] = no_data;
        flags[`FL_HE_BIT] = hw_fault;
        flags[`FL_CNC_BIT] = rx_q[`CMD_BIT_HI];
    end

    // only accel frames carry hardware errors
    always_comb begin
        resp_d = `REQ_ERR_FRAME;
        if (spi_err) begin
            resp_d = error_frame(10'h001 << `FL_SPI_BIT);
        end else if (is_accel) begin
            if (|flags) begin
                resp_d = error_frame(flags);
            end else begin
                resp_d = with_parity({2'b00, rx_q[`CMD_AXIS_BIT], 1'b0,
                    ctrl_q.selftest_enable_bit ? `ST_SELF : `ST_ACCEL, sample_sel});
            end
        end else begin
            case (op)
                `OP_WRITE: begin
                    if (ctrl_hit) begin
                        // status and parity overlay the upper address bits; low two kept
                        resp_d = with_parity({4'h0, `ST_NONE, addr[1:0], ctrl_byte(ctrl_new)});
                    end
                end
                `OP_READ: begin
                    resp_d = with_parity({4'h0, `ST_NONE, addr[1:0], rd_byte});
                end
                `OP_TEST: begin
                    resp_d = with_parity({4'h0, `ST_NONE, 2'b00, stat_byte});
                end
                default: begin
                    resp_d = `REQ_ERR_FRAME;
                end
            endcase
        end
    end

    // ==========================================================
    // register effects of a completed frame
    logic do_write;
    assign do_write = frame_end & ~spi_err & ~is_accel & (op == `OP_WRITE) & ctrl_hit;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= '0;
            ce_pulse_q <= 1'b0;
        end else begin
            ce_pulse_q <= do_write & rx_q[`CTRL_CE_BIT];
            if (do_write) begin
                ctrl_q <= ctrl_new;
            end
        end
    end

    // reset flag held until clear-error write made outside the second init phase
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            devres_q <= 1'b1;
        end else if (do_write && rx_q[`CTRL_CE_BIT] && !init_phase_two) begin
            devres_q <= 1'b0;
        end
    end

    // first request after init consumes this
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            nd_pending_q <= 1'b1;
        end else if (frame_end && !spi_err && is_accel && !init_phase_two) begin
            nd_pending_q <= 1'b0;
        end
    end

    // ==========================================================
    // queued response and transmit shifter
    logic [15:0] resp_q, tx_q;
    logic dout_q, oe_q, first_q;

    // reset value answers the missing command
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            resp_q <= `REQ_ERR_FRAME;
        end else if (frame_end) begin
            resp_q <= resp_d;
        end
    end

    // shift on falling edge, msb first
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tx_q <= `REQ_ERR_FRAME;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (load) begin
            tx_q <= resp_q;
            dout_q <= faults.osc_fault | resp_q[`FRAME_MSB];
            oe_q <= 1'b1;
        end else if (active && cs_rise) begin
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (active && sclk_fall) begin
            tx_q <= {tx_q[14:0], 1'b0};
            dout_q <= faults.osc_fault | tx_q[14];
        end else if (active) begin
            dout_q <= faults.osc_fault | tx_q[`FRAME_MSB];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            first_q <= 1'b1;
        end else if (load) begin
            first_q <= 1'b0;
        end
    end

    assign spi_dout = dout_q;
    assign spi_dout_oe = oe_q;
    assign aux_rd_addr = aux_addr_q;
    assign ctrl = ctrl_q;
    assign clear_error_pulse = ce_pulse_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_first_req_err: assert property (load && first_q |=> tx_q == `REQ_ERR_FRAME)
        else $error("first frame after reset is not the request-error frame");

    a_accel_status: assert property (frame_end && is_accel |=> resp_q[11:10] != `ST_NONE)
        else $error("acceleration answer carries status 00");

    a_accel_layout: assert property (frame_end && !spi_err && is_accel && !(|flags)
        |=> resp_q[`RSP_AXIS_BIT] == $past(rx_q[`CMD_AXIS_BIT]) && resp_q[9:0] == $past(sample_sel))
        else $error("acceleration answer axis or sample wrong");

    a_cnc_flag: assert property (frame_end && !spi_err && is_accel && rx_q[15]
        |=> resp_q[11:10] == `ST_ERROR && resp_q[`FL_CNC_BIT])
        else $error("bit 15 acceleration request not answered with conditions-wrong");

    a_spi_count: assert property (frame_end && cnt_q != `FRAME_EDGES
        |=> resp_q[`FL_SPI_BIT] && resp_q[11:10] == `ST_ERROR)
        else $error("bad edge count not reported as spi error");

    a_unused_op: assert property (frame_end && !spi_err && !is_accel && op == `OP_UNUSED
        |=> resp_q == `REQ_ERR_FRAME)
        else $error("unused operation not refused");

    a_frame_parity: assert property (^resp_q)
        else $error("queued response has even parity");

    a_osc_high: assert property (oe_q && $past(oe_q) && $past(faults.osc_fault) |-> dout_q)
        else $error("oscillator fault did not hold the output high");

    // reset flag cleared only by write
    a_devres_clear: assert property ($fell(devres_q) |-> $past(do_write && rx_q[`CTRL_CE_BIT]))
        else $error("reset flag cleared without clear-error write");

    a_idle_quiet: assert property (state_q == FR_IDLE && !cs_fall |=> $stable(rx_q) && !oe_q)
        else $error("activity taken while chip select inactive");

endmodule : accel_sensor_spi_command_slave

// *** spi_master_model.sv ***
// behavioural spi master facing the sensor command slave, mode 0
module spi_master_model (
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_din,
    input wire logic spi_dout,
    input wire logic spi_dout_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam time HALF = 32ns;
    logic alt;
    wire logic miso;
    // released line shows a moving pattern, never the last driven bit
    assign miso = spi_dout_oe ? spi_dout : alt;
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_din = 1'b0;
        alt = 1'b0;
    end
    // ==========================================================
    // frame transfer
    // clock idles low, msb first, sampled on rising edge
    // caller picks the rising-edge count to break framing on purpose
    task automatic xfer(input logic [15:0] cmd, input int edges, output logic [15:0] rsp);
        rsp = 16'h0000;
        spi_cs_n = 1'b0;
        for (int i = 0; i < edges; i++) begin
            spi_din = (i < 16) ? cmd[15 - i] : 1'b0;
            #HALF;
            spi_sclk = 1'b1;
            alt = ~alt;
            // extra edges carry no response bits
            if (i < 16)
                rsp = {rsp[14:0], miso};
            #HALF;
            spi_sclk = 1'b0;
        end
        #HALF;
        spi_cs_n = 1'b1;
        spi_din = ~spi_din;
        #(2 * HALF);
    endtask : xfer
    // ==========================================================
    // traffic for another slave
    // clock and data wiggle while chip select is high
    task automatic noise();
        for (int i = 0; i < 5; i++) begin
            spi_din = ~spi_din;
            #HALF;
            spi_sclk = 1'b1;
            #HALF;
            spi_sclk = 1'b0;
        end
        #HALF;
    endtask : noise
endmodule : spi_master_model

// *** accel_sensor_spi_command_slave_tb_top.sv ***
// self-checking bench of the sensor spi command slave
module accel_sensor_spi_command_slave_tb_top import accel_spi_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, sys_rst, init_phase_one, init_phase_two, clear_error_pulse;
    logic ce_seen = 1'b0;
    wire logic spi_cs_n, spi_sclk, spi_din, spi_dout, spi_dout_oe;
    sensor_faults_t faults;
    ctrl_bits_t ctrl;
    logic [9:0] sample_x, sample_y;
    logic [7:0] aux_rd_data;
    logic [4:0] aux_rd_addr;
    logic [15:0] pend_exp, pend_mask, rsp;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    // ==========================================================
    // instances
    accel_sensor_spi_command_slave u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_din(spi_din), .spi_dout(spi_dout),
        .spi_dout_oe(spi_dout_oe), .init_phase_one(init_phase_one),
        .init_phase_two(init_phase_two), .faults(faults), .sample_x(sample_x),
        .sample_y(sample_y), .aux_rd_data(aux_rd_data), .aux_rd_addr(aux_rd_addr),
        .ctrl(ctrl), .clear_error_pulse(clear_error_pulse));
    spi_master_model u_master (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_din(spi_din),
        .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe));
    // ==========================================================
    // helpers
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic cmp_frame(input logic [15:0] got, input logic [15:0] exp,
                             input logic [15:0] mask);
        checks++;
        if ((got & mask) !== (exp & mask)) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got & mask, exp & mask);
        end
    endtask : cmp_frame
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_frame(got, exp, 16'hffff);
    endtask : cmp_val
    function automatic logic [15:0] par(input logic [15:0] f);
        return f | {3'b000, ~^f, 12'h000};
    endfunction : par
    function automatic logic [15:0] acc(input logic ax, input logic st, input logic [9:0] s);
        return par({2'b00, ax, 1'b0, st ? 2'b10 : 2'b01, s});
    endfunction : acc
    // answer arrives one frame late, so each call checks the previous command
    task automatic op(input logic [15:0] cmd, input logic [15:0] exp, input logic [15:0] mask,
                      input int edges = 16);
        u_master.xfer(cmd, edges, rsp);
        if (pend_mask !== 16'h0000)
            cmp_frame(rsp, pend_exp, pend_mask);
        // odd parity on every checked frame except one expected as 16'hffff
        if (pend_mask !== 16'h0000 && pend_exp !== 16'hffff)
            cmp_val({15'h0000, ^rsp}, 16'h0001);
        pend_exp = exp;
        pend_mask = mask;
    endtask : op
    // ==========================================================
    // clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (clear_error_pulse === 1'b1)
            ce_seen <= 1'b1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] d;
        logic ax;
        logic [9:0] s;
        int seed;
        sys_rst = 1'b1;
        init_phase_one = 1'b0;
        init_phase_two = 1'b0;
        faults = '0;
        sample_x = 10'h000;
        sample_y = 10'h000;
        aux_rd_data = 8'h00;
        pend_exp = 16'h0c02;
        pend_mask = 16'hffff;
        seed = $urandom(48994);
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        op(16'hc000, 16'h0009, 16'h0cff);
        op(16'h2000, 16'h0c10, 16'h0fff);
        // clear-error together with bypass and self-test enable
        op(16'h4a19, 16'h0009, 16'h0cff);
        cmp_val({13'h0000, ctrl}, 16'h0005);
        cmp_val({15'h0000, ce_seen}, 16'h0001);
        u_master.noise();
        op(16'hc000, 16'h0000, 16'h0cff);
        @(negedge clk_sys);
        aux_rd_data = 8'($urandom);
        op({8'h8a, 8'($urandom)}, 16'h0009, 16'h0cff);
        op({8'h85, 8'($urandom)}, {8'h00, aux_rd_data}, 16'h0cff);
        cmp_val({11'h000, aux_rd_addr}, 16'h0005);
        op(16'h4505, 16'h0c02, 16'hffff);
        op({3'b000, 13'($urandom)}, 16'h0c02, 16'hffff);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom) & 8'h0b;
            ax = 1'($urandom);
            s = (i == 0) ? 10'h200 : 10'($urandom);
            @(negedge clk_sys);
            sample_x = ax ? ~s : s;
            sample_y = ax ? s : ~s;
            op({8'h4a, d}, {8'h00, d}, 16'h0cff);
            op({1'b0, ax, 14'h2000}, acc(ax, d[0], s), 16'hffff);
            cmp_val({13'h0000, ctrl}, {13'h0000, d[3], d[1], d[0]});
        end
        op(16'ha000, 16'h0c20, 16'h0fff);
        for (int i = 0; i < 6; i++) begin
            if (i == 3 || i == 4)
                continue;
            @(negedge clk_sys);
            faults = sensor_faults_t'(6'h01 << i);
            op(16'h2000, 16'h0c08, 16'h0fff);
        end
        op(16'ha000, 16'h0c28, 16'h0fff);
        @(negedge clk_sys);
        faults = '0;
        op(16'h2000, 16'hffff, 16'hffff);
        @(negedge clk_sys);
        faults.osc_fault = 1'b1;
        faults.osc_running = 1'b1;
        op(16'h2000, 16'h0000, 16'h0000);
        @(negedge clk_sys);
        faults = '0;
        op(16'hc000, 16'h0c04, 16'hffff, 15);
        op(16'h6000, 16'h0c04, 16'hffff, 17);
        op(16'hc000, {12'h000, ~d[3], 3'b000}, 16'h0cff);
        // second reset straight into the two start-up phases
        @(negedge clk_sys);
        sys_rst = 1'b1;
        init_phase_one = 1'b1;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        pend_exp = 16'h0c02;
        pend_mask = 16'hffff;
        u_master.xfer(16'h4a0b, 16, rsp);
        cmp_val({13'h0000, ctrl}, 16'h0000);
        @(negedge clk_sys);
        init_phase_one = 1'b0;
        init_phase_two = 1'b1;
        op(16'h2000, 16'h0c10, 16'h0fff);
        op(16'h4a0b, 16'h000b, 16'h0cff);
        @(negedge clk_sys);
        init_phase_two = 1'b0;
        op(16'h2000, 16'h0c10, 16'h0fff);
        op(16'hc000, 16'h0001, 16'h0cff);
        op(16'h6000, acc(1'b1, 1'b1, sample_y), 16'hffff);
        op(16'hc000, 16'h0000, 16'h0000);
        complete_run();
    end
endmodule : accel_sensor_spi_command_slave_tb_top
